// [oss_pkg.sv]
// Constants, field layouts and carrier types of the oscillator source switch
package oss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_HZ = 50_000_000;
  localparam int unsigned INT_OSC_HZ = 4_000_000;
  localparam logic [3:0] INT_HALF_CYC = 4'(MCLK_HZ / (2 * INT_OSC_HZ));
  localparam logic [3:0] TRIM_CENTER = 4'h2;
  localparam logic [1:0] EDGES_TO_SWITCH = 2'h2;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_TRIM = 8'h08;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_AUXEN_BIT = 2;
  localparam int STAT_REQ_BIT = 0;
  localparam int STAT_ENG_BIT = 1;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam int SY_PIN = 0;
  localparam int SY_RC = 1;
  localparam int SY_XTAL = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_RC, SRC_XTAL} oss_src_t;
  typedef enum logic [1:0] {SW_INT, SW_CHECK, SW_SWITCH, SW_ENGAGED} oss_phase_t;

  typedef struct packed {
    logic full;
    logic half;
  } oss_clk_t;

  typedef struct packed {
    logic auxOut;
    logic auxOe;
    logic portFn;
    logic osc1ClkIn;
  } oss_pins_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic prevExt;
    logic [3:0] intCnt;
    logic internal_osc_clock;
    logic intRun;
    oss_src_t srcSel;
    logic auxOutEn;
    logic external_clock_request;
    logic external_clock_engaged;
    logic [7:0] trim;
    oss_src_t engSrc;
    oss_phase_t phase;
    logic [1:0] edgeCnt;
    oss_clk_t clk;
    oss_pins_t pins;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } oss_state_t;

  localparam oss_state_t OSS_STATE_RST = '{
    trim: TRIM_RST, intRun: 1'b1, srcSel: SRC_INT, engSrc: SRC_INT,
    phase: SW_INT, default: '0};

endpackage

// [oss_source_switch.sv]
// Oscillator source selection, glitch-free switch to external clock, clock outputs and aux pin control
// Contract
// - Select field: 00 internal, 01 external clock, 10 RC, 11 crystal.
// - External source selected: input pin becomes clock input; crystal also takes aux pin.
// - After request, count two external rising edges before switching.
// - Changeover from internal to external is glitch free.
// - Set engaged status first, then stop internal oscillator.
// - Only reset restarts internal oscillator; no fallback if external clock fails.
// - External clock: pin clock is full rate, divided by two for half rate.
// - External clock: aux pin is port bit four; aux clock enable ignored.
// - Crystal: aux pin is inverted amplifier output; aux clock enable ignored.
// - Internal or RC: aux enable 0 gives port bit, 1 outputs full rate clock.
// - Oscillator run enable gates whichever oscillator is in use.
// - Full rate clock equals selected source clock, sent to integration unit.
// - Half rate clock is half of full rate.
// - Internal oscillator nominal 4.0 MHz, adjustable by trim.
// - Wait mode leaves oscillator logic and both clocks running.
// - Stop mode disables the source, stopping both clock outputs.
// - Break state keeps both clock outputs running.
// - Reset clears request bit; request ignored in monitor bypass mode.
// - Engaged status is read-only: 1 when external source drives system clock.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module oss_source_switch
  import oss_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // From integration unit, same clock
  input wire logic oscRunEnable,
  input wire logic stopMode,
  input wire logic monitorBypass,
  // Asynchronous source levels
  input wire logic oscInPin,
  input wire logic crystal_clock,
  input wire logic resistor_cap_clock,
  // Clock and pin outputs
  output oss_clk_t clkOut,
  output oss_pins_t pinCtl
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == OFF_CFG) || (addr == OFF_STAT) || (addr == OFF_TRIM);
  endfunction

  oss_state_t st_ff;
  oss_state_t nxt_st;

  logic [1:0] watchSrc;
  logic extLvl;
  logic extRise;
  logic runEn;
  logic curLvl;
  logic [3:0] halfPer;
  logic reqValid;
  logic apbAccess;
  logic apbDone;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Two-stage synchronisers; only stage two is used
    nxt_st.sync1 = {crystal_clock, resistor_cap_clock, oscInPin};
    nxt_st.sync2 = st_ff.sync1;
    // Before the request the watched source follows the select field
    watchSrc = (st_ff.phase == SW_INT) ? st_ff.srcSel : st_ff.engSrc;
    case (watchSrc)
      SRC_EXT: extLvl = st_ff.sync2[SY_PIN];
      SRC_RC: extLvl = st_ff.sync2[SY_RC];
      SRC_XTAL: extLvl = st_ff.sync2[SY_XTAL];
      default: extLvl = 1'b0;
    endcase
    extRise = extLvl & ~st_ff.prevExt;
    nxt_st.prevExt = extLvl;
    // Only run enable and stop gate the source; wait and break have no effect
    runEn = oscRunEnable & ~stopMode;
    reqValid = st_ff.external_clock_request & ~monitorBypass;

    // Internal oscillator; trim stretches or shortens the half period
    halfPer = INT_HALF_CYC - TRIM_CENTER + {2'h0, st_ff.trim[7:6]};
    if (st_ff.intRun && runEn) begin
      if (st_ff.intCnt >= halfPer - 4'h1) begin
        nxt_st.intCnt = 4'h0;
        nxt_st.internal_osc_clock = ~st_ff.internal_osc_clock;
      end else begin
        nxt_st.intCnt = st_ff.intCnt + 4'h1;
      end
    end else begin
      nxt_st.intCnt = 4'h0;
      nxt_st.internal_osc_clock = 1'b0;
    end

    // Switch sequencer
    case (st_ff.phase)
      SW_INT: begin
        nxt_st.edgeCnt = 2'h0;
        if (reqValid && st_ff.srcSel != SRC_INT) begin
          nxt_st.engSrc = st_ff.srcSel;
          nxt_st.phase = SW_CHECK;
        end
      end
      SW_CHECK: begin
        if (!reqValid) begin
          nxt_st.phase = SW_INT;
        end else if (extRise) begin
          nxt_st.edgeCnt = st_ff.edgeCnt + 2'h1;
          if (st_ff.edgeCnt + 2'h1 == EDGES_TO_SWITCH) begin
            nxt_st.phase = SW_SWITCH;
          end
        end
      end
      SW_SWITCH: begin
        // Hand over only while both clocks are low, so no runt pulse
        if (!st_ff.internal_osc_clock && !extLvl) begin
          nxt_st.external_clock_engaged = 1'b1;
          nxt_st.phase = SW_ENGAGED;
        end
      end
      SW_ENGAGED: begin
        // No clock monitor: stays external until reset
        nxt_st.intRun = 1'b0;
      end
      default: nxt_st.phase = SW_INT;
    endcase

    // Clock outputs
    curLvl = st_ff.external_clock_engaged ? extLvl : st_ff.internal_osc_clock;
    nxt_st.clk.full = curLvl & runEn;
    if (nxt_st.clk.full && !st_ff.clk.full) begin
      nxt_st.clk.half = ~st_ff.clk.half;
    end

    // Pin functions
    nxt_st.pins.osc1ClkIn = (st_ff.srcSel != SRC_INT);
    case (st_ff.srcSel)
      SRC_XTAL: begin
        nxt_st.pins.auxOut = ~st_ff.sync2[SY_PIN];
        nxt_st.pins.auxOe = 1'b1;
        nxt_st.pins.portFn = 1'b0;
      end
      SRC_EXT: begin
        nxt_st.pins.auxOut = 1'b0;
        nxt_st.pins.auxOe = 1'b0;
        nxt_st.pins.portFn = 1'b1;
      end
      default: begin
        nxt_st.pins.auxOut = st_ff.auxOutEn & curLvl & runEn;
        nxt_st.pins.auxOe = st_ff.auxOutEn;
        nxt_st.pins.portFn = ~st_ff.auxOutEn;
      end
    endcase

    // APB: one wait state, answer on the second access cycle
    apbAccess = psel & penable & ~st_ff.pready;
    apbDone = psel & penable & st_ff.pready;
    nxt_st.pready = apbAccess;
    nxt_st.pslverr = apbAccess & ~isMapped(paddr);
    nxt_st.prdata = 32'h0000_0000;
    if (apbAccess && !pwrite) begin
      case (paddr)
        OFF_CFG: begin
          nxt_st.prdata[CFG_SEL_LSB +: 2] = st_ff.srcSel;
          nxt_st.prdata[CFG_AUXEN_BIT] = st_ff.auxOutEn;
        end
        OFF_STAT: begin
          nxt_st.prdata[STAT_REQ_BIT] = st_ff.external_clock_request;
          nxt_st.prdata[STAT_ENG_BIT] = st_ff.external_clock_engaged;
        end
        OFF_TRIM: nxt_st.prdata[7:0] = st_ff.trim;
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end
    if (apbDone && pwrite) begin
      case (paddr)
        OFF_CFG: begin
          nxt_st.srcSel = oss_src_t'(pwdata[CFG_SEL_LSB +: 2]);
          nxt_st.auxOutEn = pwdata[CFG_AUXEN_BIT];
        end
        OFF_STAT: nxt_st.external_clock_request = pwdata[STAT_REQ_BIT];
        OFF_TRIM: nxt_st.trim = pwdata[7:0];
        default: nxt_st.trim = st_ff.trim;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= OSS_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign clkOut = st_ff.clk;
  assign pinCtl = st_ff.pins;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_status_before_stop: assert property ($fell(st_ff.intRun) |-> $past(st_ff.external_clock_engaged, 1) && $past(st_ff.intRun, 1))
    else $error("internal oscillator stopped before status set");
  a_engaged_sticky: assert property (st_ff.external_clock_engaged |=> st_ff.external_clock_engaged && !st_ff.intRun)
    else $error("engaged status dropped or internal oscillator restarted");
  a_int_runs_internal: assert property (!st_ff.external_clock_engaged |-> st_ff.intRun)
    else $error("internal oscillator stopped while not engaged");
  a_two_edges_seen: assert property ($rose(st_ff.external_clock_engaged) |-> st_ff.edgeCnt == EDGES_TO_SWITCH)
    else $error("switched without two external edges");
  a_switch_when_low: assert property ($rose(st_ff.external_clock_engaged) |-> $past(st_ff.internal_osc_clock, 1) == 1'b0 && !st_ff.clk.full)
    else $error("switch taken while a clock was high");
  a_half_follows: assert property ($rose(st_ff.clk.full) |-> st_ff.clk.half != $past(st_ff.clk.half, 1))
    else $error("half rate did not toggle on full rate edge");
  a_stop_gates: assert property (stopMode |=> !st_ff.clk.full ##1 !st_ff.clk.full || !$past(stopMode, 1))
    else $error("clock ran during stop");
  a_ext_port_pin: assert property (st_ff.srcSel == SRC_EXT |=> st_ff.pins.portFn && !st_ff.pins.auxOe)
    else $error("aux pin not port bit with external clock");
  a_xtal_aux_out: assert property (st_ff.srcSel == SRC_XTAL |=> st_ff.pins.auxOe && !st_ff.pins.portFn)
    else $error("aux pin not crystal output");
  a_osc_input_pin_input: assert property (st_ff.srcSel != SRC_INT |=> st_ff.pins.osc1ClkIn)
    else $error("input pin not a clock input");
  a_bypass_blocks: assert property (monitorBypass && st_ff.phase == SW_INT |=> st_ff.phase == SW_INT)
    else $error("request acted on in monitor bypass");
  a_apb_answer: assert property (psel && penable && !st_ff.pready |=> st_ff.pready ##1 !st_ff.pready)
    else $error("apb answer not one cycle after access");

endmodule

`default_nettype wire

// [oss_source_switch_tb_top.sv]
// Self-checking bench for the oscillator source switch
`timescale 1ns/1ps
`default_nettype none

module oss_source_switch_tb_top;
  import oss_pkg::*;
  logic mclk, rst, psel, penable, pwrite, oscRunEnable, stopMode, monitorBypass, run, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, t;
  logic oscInPin, crystal_clock, resistor_cap_clock;
  oss_clk_t clkOut;
  oss_pins_t pinCtl;
  logic [33:0] expQ[$];
  int num_errors = 0;
  int total_checks = 0;
  int n;

  oss_src_model src_u (.run(run), .oscInPin(oscInPin), .crystal_clock(crystal_clock), .resistor_cap_clock(resistor_cap_clock));
  oss_source_switch dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscRunEnable(oscRunEnable), .stopMode(stopMode), .monitorBypass(monitorBypass),
    .oscInPin(oscInPin), .crystal_clock(crystal_clock), .resistor_cap_clock(resistor_cap_clock), .clkOut(clkOut), .pinCtl(pinCtl));

  // -----------------------------------------------------------
  // Checking and bus tasks
  // -----------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit chk,
                     input logic [31:0] exp, input logic err);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (chk) expQ.push_back({w, err, exp});
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    if (i == 20) begin
      num_errors++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sampled rise-to-rise distance in mclk cycles
  task automatic period(input bit useHalf, output int p);
    logic prev, cur;
    int i, first;
    p = 0;
    first = -1;
    prev = 1'b1;
    for (i = 0; i < 300 && p == 0; i++) begin
      @(posedge mclk);
      cur = useHalf ? clkOut.half : clkOut.full;
      if (cur === 1'b1 && prev === 1'b0) begin
        if (first < 0) first = i;
        else p = i - first;
      end
      prev = cur;
    end
  endtask

  // Counts cycles in which the full-rate clock was not low
  task automatic quiet(output int q);
    q = 0;
    repeat (6) @(posedge mclk);
    repeat (30) begin
      @(posedge mclk);
      if (clkOut.full !== 1'b0) q++;
    end
  endtask

  always @(posedge mclk) begin
    if (pready === 1'b1 && expQ.size() > 0) begin
      if (!expQ[0][33]) check("prdata", prdata, expQ[0][31:0]);
      check("pslverr", {31'h0, pslverr}, {31'h0, expQ[0][32]});
      void'(expQ.pop_front());
    end
  end

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    {rst, run, oscRunEnable} = 3'h7;
    {psel, penable, pwrite, stopMode, monitorBypass} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(48));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(0, OFF_CFG, 0, 1, 32'h0000_0000, 0);
    apb(0, OFF_STAT, 0, 1, 32'h0000_0000, 0);
    apb(0, OFF_TRIM, 0, 1, 32'h0000_0080, 0);
    apb(0, 8'h0C, 0, 1, 32'h0000_0000, 1);
    period(0, n);
    check("intPeriod", 32'(n), 32'h0000_000C);
    $display("test reset done");
    repeat (3) begin
      t = {24'h0, 8'($urandom())};
      apb(1, OFF_TRIM, t, 1, 0, 0);
      apb(0, OFF_TRIM, 0, 1, t, 0);
      period(0, n);
      check("trimPeriod", 32'(n), 32'(2 * (4 + t[7:6])));
    end
    apb(1, OFF_TRIM, 32'h0000_0080, 1, 0, 0);
    $display("test trim done");
    for (int s = 0; s < 8; s++) begin
      apb(1, OFF_CFG, 32'(s), 1, 0, 0);
      apb(0, OFF_CFG, 0, 1, 32'(s), 0);
      repeat (3) @(posedge mclk);
      t[2] = (s[1:0] == 2'h3) || (s[2] && !s[0]);
      check("pins", {29'h0, pinCtl.auxOe, pinCtl.portFn, pinCtl.osc1ClkIn},
            {29'h0, t[2], !t[2], s[1:0] != 2'h0});
      if (s[1:0] != 2'h3) check("auxOut", {31'h0, pinCtl.auxOut}, {31'h0, t[2] & clkOut.full});
    end
    $display("test aux pin done");
    apb(1, OFF_CFG, 32'h0000_0002, 1, 0, 0);
    repeat (100) @(posedge mclk);
    monitorBypass <= 1'b1;
    apb(1, OFF_STAT, 32'h0000_0001, 1, 0, 0);
    repeat (40) @(posedge mclk);
    apb(0, OFF_STAT, 0, 1, 32'h0000_0001, 0);
    period(0, n);
    check("bypassPeriod", 32'(n), 32'h0000_000C);
    monitorBypass <= 1'b0;
    for (int i = 0; i < 30 && rd[1] !== 1'b1; i++) apb(0, OFF_STAT, 0, 0, 0, 0);
    apb(0, OFF_STAT, 0, 1, 32'h0000_0003, 0);
    period(0, n);
    check("rcPeriod", 32'(n), 32'h0000_0007);
    period(1, n);
    check("halfPeriod", 32'(n), 32'h0000_000E);
    apb(1, OFF_STAT, 32'h0000_0002, 1, 0, 0);
    apb(0, OFF_STAT, 0, 1, 32'h0000_0002, 0);
    $display("test switch done");
    stopMode <= 1'b1;
    quiet(n);
    check("stopQuiet", 32'(n), 32'h0000_0000);
    stopMode <= 1'b0;
    oscRunEnable <= 1'b0;
    quiet(n);
    check("runQuiet", 32'(n), 32'h0000_0000);
    oscRunEnable <= 1'b1;
    run <= 1'b0;
    quiet(n);
    check("deadQuiet", 32'(n), 32'h0000_0000);
    apb(0, OFF_STAT, 0, 1, 32'h0000_0002, 0);
    apb(1, OFF_CFG, 32'h0000_0003, 1, 0, 0);
    repeat (3) @(posedge mclk);
    check("xtalAux", {30'h0, pinCtl.auxOut, pinCtl.auxOe}, 32'h0000_0003);
    $display("test stop done");
    // Second reset brings the internal oscillator back; then engage the pin clock
    rst <= 1'b1;
    run <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(0, OFF_STAT, 0, 1, 32'h0000_0000, 0);
    period(0, n);
    check("restartPeriod", 32'(n), 32'h0000_000C);
    apb(1, OFF_CFG, 32'h0000_0001, 1, 0, 0);
    repeat (20) @(posedge mclk);
    apb(1, OFF_STAT, 32'h0000_0001, 1, 0, 0);
    for (int i = 0; i < 30 && rd[1] !== 1'b1; i++) apb(0, OFF_STAT, 0, 0, 0, 0);
    apb(0, OFF_STAT, 0, 1, 32'h0000_0003, 0);
    period(0, n);
    check("extPeriod", 32'(n), 32'h0000_0005);
    period(1, n);
    check("extHalf", 32'(n), 32'h0000_000A);
    $display("test pin clock done");
    conclude();
  end
endmodule

`default_nettype wire

// [oss_src_model.sv]
// Behavioural far-side clock sources: external pin clock, crystal and RC
`timescale 1ns/1ps
`default_nettype none

module oss_src_model (
  // Control from the bench
  input wire logic run,
  // Source levels
  output logic oscInPin,
  output logic crystal_clock,
  output logic resistor_cap_clock
);
  // -----------------------------------------------------------
  // Sources
  // -----------------------------------------------------------
  // Edges end in 7 ns so they never meet an mclk edge; a dead source sits low
  initial begin
    oscInPin = 1'b0;
    crystal_clock = 1'b0;
    resistor_cap_clock = 1'b0;
    #7;
    fork
      forever #50 oscInPin = run & ~oscInPin;
      forever #90 crystal_clock = run & ~crystal_clock;
      forever #70 resistor_cap_clock = run & ~resistor_cap_clock;
    join
  end
endmodule

`default_nettype wire
